// [src/vsc_pkg.sv]
package vsc_pkg;
	localparam int WORD_W = 64;
	localparam int ELEM_N = 64;
	localparam int IDX_W = 6;
	localparam int CNT_W = 7;
	localparam int ADDR_W = 32;
	localparam int FU_LAT = 5;
	localparam logic [WORD_W-1:0] WORD_ZERO = 64'h0;
	localparam logic [CNT_W-1:0] CNT_ZERO = 7'h0;
	localparam logic [CNT_W-1:0] CNT_ONE = 7'h1;
	localparam logic [IDX_W-1:0] IDX_ZERO = 6'h0;
	localparam logic [IDX_W-1:0] IDX_ONE = 6'h1;
	localparam logic [IDX_W-1:0] IDX_LAST = 6'h3f;
	localparam logic [ADDR_W-1:0] ADDR_ZERO = 32'h0;
	localparam logic [FU_LAT-1:0] PIPE_ZERO = 5'h0;
	localparam logic [WORD_W-1:0] MASK_RST = 64'h0;
	localparam int SIGN_BIT = 63;
	// Operation select
	typedef enum logic [2:0] {
		VSC_OP_VV,
		VSC_OP_VS,
		VSC_OP_LOAD,
		VSC_OP_STORE,
		VSC_OP_GATHER,
		VSC_OP_SCATTER,
		VSC_OP_CIDX
	} vsc_op_e;
	// Compressed index test select
	typedef enum logic [1:0] {
		VSC_T_ZERO,
		VSC_T_NZ,
		VSC_T_POS,
		VSC_T_NEG
	} vsc_test_e;
	typedef enum logic [1:0] {
		VSC_IDLE,
		VSC_RUN,
		VSC_DRAIN
	} vsc_state_e;
endpackage : vsc_pkg

// [src/vsc_seq.sv]
`timescale 1ns/1ps
module vsc_seq
	import vsc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic start,
	input wire vsc_op_e op_sel,
	input wire vsc_test_e test_sel,
	input wire logic merge_en,
	input wire logic [CNT_W-1:0] element_count_reg,
	input wire logic [WORD_W-1:0] scalar_operand,
	input wire logic [ADDR_W-1:0] base_address_reg,
	input wire logic [ADDR_W-1:0] addr_increment,
	input wire logic src_valid,
	input wire logic [WORD_W-1:0] first_source_vector,
	input wire logic [WORD_W-1:0] second_source_vector,
	input wire logic [WORD_W-1:0] index_vector_reg,
	input wire logic [WORD_W-1:0] fu_result,
	input wire logic chain_req,
	input wire logic mask_we,
	input wire logic [WORD_W-1:0] mask_wdata,
	output logic busy,
	output logic [IDX_W-1:0] src_elem,
	output logic fu_issue,
	output logic [WORD_W-1:0] fu_opa_ff,
	output logic [WORD_W-1:0] fu_opb_ff,
	output logic mem_req_ff,
	output logic mem_we_ff,
	output logic [ADDR_W-1:0] mem_addr_ff,
	output logic [WORD_W-1:0] mem_wdata_ff,
	output logic dst_we_ff,
	output logic [IDX_W-1:0] dst_elem_ff,
	output logic [WORD_W-1:0] dst_data_ff,
	output logic [CNT_W-1:0] written_cnt_ff,
	output logic chain_ok,
	output logic chain_full_ff,
	output logic [WORD_W-1:0] element_mask_reg
);
	vsc_state_e state_ff;
	vsc_op_e op_ff;
	vsc_test_e test_ff;
	logic merge_ff;
	logic [CNT_W-1:0] len_ff;
	logic [CNT_W-1:0] issued_ff;
	logic [WORD_W-1:0] scalar_ff;
	logic [ADDR_W-1:0] base_ff;
	logic [ADDR_W-1:0] incr_ff;
	logic [ADDR_W-1:0] addr_ff;
	logic [FU_LAT-1:0] pipe_v_ff;
	logic [IDX_W-1:0] pipe_i_ff [FU_LAT];
	logic [IDX_W-1:0] cidx_ff;
	logic [WORD_W-1:0] mask_ff;
	logic issue;
	logic last_issue;
	logic ret;
	logic [IDX_W-1:0] ret_idx;
	logic is_mem;
	logic cidx_hit;
	logic [WORD_W-1:0] nxt_mask;

	// Mask bit position of an element, MSB first
	function automatic logic [IDX_W-1:0] mask_pos(input logic [IDX_W-1:0] e);
		mask_pos = IDX_LAST - e;
	endfunction : mask_pos

	// Element address from base and a 64-bit index
	function automatic logic [ADDR_W-1:0] idx_addr(input logic [ADDR_W-1:0] b,
		input logic [WORD_W-1:0] i);
		idx_addr = b + i[ADDR_W-1:0];
	endfunction : idx_addr

	// Compressed index element test
	function automatic logic elem_test(input vsc_test_e t, input logic [WORD_W-1:0] w);
		unique case (t)
			VSC_T_ZERO: elem_test = (w == WORD_ZERO);
			VSC_T_NZ: elem_test = (w != WORD_ZERO);
			VSC_T_POS: elem_test = !w[SIGN_BIT] && (w != WORD_ZERO);
			VSC_T_NEG: elem_test = w[SIGN_BIT];
		endcase
	endfunction : elem_test

	// Source stalls when its element is not yet there, so a chained load paces us
	assign issue = (state_ff == VSC_RUN) && src_valid;
	assign last_issue = issue && (issued_ff + CNT_ONE == len_ff);
	assign busy = (state_ff != VSC_IDLE);
	assign src_elem = issued_ff[IDX_W-1:0];
	assign fu_issue = issue && ((op_ff == VSC_OP_VV) || (op_ff == VSC_OP_VS));
	assign is_mem = (op_ff == VSC_OP_LOAD) || (op_ff == VSC_OP_STORE)
		|| (op_ff == VSC_OP_GATHER) || (op_ff == VSC_OP_SCATTER);
	assign ret = pipe_v_ff[FU_LAT-1];
	assign ret_idx = pipe_i_ff[FU_LAT-1];
	// Consumer may follow any element already written
	assign chain_ok = busy && (written_cnt_ff != CNT_ZERO || dst_we_ff);
	assign cidx_hit = elem_test(test_ff, first_source_vector);
	assign element_mask_reg = mask_ff;

	// Sequencer state
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
			state_ff <= VSC_IDLE;
		else
			unique case (state_ff)
				VSC_IDLE: if (start)
					state_ff <= (element_count_reg == CNT_ZERO) ? VSC_IDLE : VSC_RUN;
				VSC_RUN: if (last_issue)
					state_ff <= VSC_DRAIN;
				VSC_DRAIN: if (pipe_v_ff == PIPE_ZERO)
					state_ff <= VSC_IDLE;
			endcase
	end

	// Instruction context captured at start; scalar held for broadcast
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			op_ff <= VSC_OP_VV;
			test_ff <= VSC_T_ZERO;
			merge_ff <= 1'b0;
			len_ff <= CNT_ZERO;
			scalar_ff <= WORD_ZERO;
			base_ff <= ADDR_ZERO;
			incr_ff <= ADDR_ZERO;
		end
		else if (start && state_ff == VSC_IDLE)
		begin
			op_ff <= op_sel;
			test_ff <= test_sel;
			merge_ff <= merge_en;
			len_ff <= element_count_reg;
			scalar_ff <= scalar_operand;
			base_ff <= base_address_reg;
			incr_ff <= addr_increment;
		end
	end

	// Element issue counter
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
			issued_ff <= CNT_ZERO;
		else if (start && state_ff == VSC_IDLE)
			issued_ff <= CNT_ZERO;
		else if (issue)
			issued_ff <= issued_ff + CNT_ONE;
	end

	// Operands into the unit; vector-scalar sends the held scalar each time
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			fu_opa_ff <= WORD_ZERO;
			fu_opb_ff <= WORD_ZERO;
		end
		else if (fu_issue)
		begin
			fu_opa_ff <= first_source_vector;
			fu_opb_ff <= (op_ff == VSC_OP_VS) ? scalar_ff : second_source_vector;
		end
	end

	// Fixed-latency tracking of element indices through the unit or memory path
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			pipe_v_ff <= PIPE_ZERO;
			for (int k = 0; k < FU_LAT; k++)
				pipe_i_ff[k] <= IDX_ZERO;
		end
		else
		begin
			pipe_v_ff <= {pipe_v_ff[FU_LAT-2:0], issue && (op_ff != VSC_OP_STORE)
				&& (op_ff != VSC_OP_SCATTER) && (op_ff != VSC_OP_CIDX)};
			pipe_i_ff[0] <= issued_ff[IDX_W-1:0];
			for (int k = 1; k < FU_LAT; k++)
				pipe_i_ff[k] <= pipe_i_ff[k-1];
		end
	end

	// Memory addressing: strided or base plus index
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			mem_req_ff <= 1'b0;
			mem_we_ff <= 1'b0;
			mem_addr_ff <= ADDR_ZERO;
			mem_wdata_ff <= WORD_ZERO;
			addr_ff <= ADDR_ZERO;
		end
		else
		begin
			mem_req_ff <= issue && is_mem;
			mem_we_ff <= issue && ((op_ff == VSC_OP_STORE) || (op_ff == VSC_OP_SCATTER));
			if (start && state_ff == VSC_IDLE)
				addr_ff <= base_address_reg;
			else if (issue && is_mem)
			begin
				unique case (op_ff)
					VSC_OP_GATHER, VSC_OP_SCATTER:
						mem_addr_ff <= idx_addr(base_ff, index_vector_reg);
					default:
					begin
						mem_addr_ff <= addr_ff;
						addr_ff <= addr_ff + incr_ff;
					end
				endcase
				mem_wdata_ff <= first_source_vector;
			end
		end
	end

	// Destination writes; merge writes zero where mask bit is clear
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			dst_we_ff <= 1'b0;
			dst_elem_ff <= IDX_ZERO;
			dst_data_ff <= WORD_ZERO;
			cidx_ff <= IDX_ZERO;
		end
		else
		begin
			dst_we_ff <= ret || (issue && op_ff == VSC_OP_CIDX && cidx_hit);
			if (start && state_ff == VSC_IDLE)
				cidx_ff <= IDX_ZERO;
			if (ret)
			begin
				dst_elem_ff <= ret_idx;
				dst_data_ff <= (merge_ff && !mask_ff[mask_pos(ret_idx)])
					? WORD_ZERO : fu_result;
			end
			else if (issue && op_ff == VSC_OP_CIDX && cidx_hit)
			begin
				dst_elem_ff <= cidx_ff;
				dst_data_ff <= {{(WORD_W-IDX_W){1'b0}}, issued_ff[IDX_W-1:0]};
				cidx_ff <= cidx_ff + IDX_ONE;
			end
		end
	end

	// Written count and chaining class
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			written_cnt_ff <= CNT_ZERO;
			chain_full_ff <= 1'b0;
		end
		else if (start && state_ff == VSC_IDLE)
		begin
			written_cnt_ff <= CNT_ZERO;
			chain_full_ff <= 1'b0;
		end
		else
		begin
			if (dst_we_ff)
				written_cnt_ff <= written_cnt_ff + CNT_ONE;
			if (chain_req && dst_we_ff && written_cnt_ff == CNT_ZERO)
				chain_full_ff <= 1'b1;
		end
	end

	// Mask: software write, else test result per element
	always_comb
	begin
		nxt_mask = mask_ff;
		if (issue && op_ff == VSC_OP_CIDX)
			nxt_mask[mask_pos(issued_ff[IDX_W-1:0])] = cidx_hit;
		else if (mask_we && !busy)
			nxt_mask = mask_wdata;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
			mask_ff <= MASK_RST;
		else
			mask_ff <= nxt_mask;
	end

	AST_STOP_AT_COUNT: assert property (@(posedge sys_clk) disable iff (!nrst)
		last_issue |=> state_ff != VSC_RUN)
		else $error("run continued past element count");
	AST_LATENCY: assert property (@(posedge sys_clk) disable iff (!nrst)
		(issue && op_ff inside {VSC_OP_VV, VSC_OP_VS, VSC_OP_LOAD, VSC_OP_GATHER}) |-> ##5 ret)
		else $error("result latency wrong");
	AST_VS_BCAST: assert property (@(posedge sys_clk) disable iff (!nrst)
		(fu_issue && op_ff == VSC_OP_VS) |=> fu_opb_ff == scalar_ff)
		else $error("scalar not broadcast");
	AST_STRIDE: assert property (@(posedge sys_clk) disable iff (!nrst)
		(issue && op_ff == VSC_OP_LOAD) |=> addr_ff == $past(addr_ff) + incr_ff)
		else $error("stride step wrong");
	AST_GATHER_ADDR: assert property (@(posedge sys_clk) disable iff (!nrst)
		(issue && op_ff == VSC_OP_GATHER) |=> mem_req_ff && !mem_we_ff
		&& mem_addr_ff == base_ff + $past(index_vector_reg[ADDR_W-1:0]))
		else $error("gather address wrong");
	AST_SCATTER_WR: assert property (@(posedge sys_clk) disable iff (!nrst)
		(issue && op_ff == VSC_OP_SCATTER) |=> mem_we_ff
		&& mem_wdata_ff == $past(first_source_vector))
		else $error("scatter write wrong");
	AST_CIDX_MASK: assert property (@(posedge sys_clk) disable iff (!nrst)
		(issue && op_ff == VSC_OP_CIDX && test_ff == VSC_T_NZ)
		|=> mask_ff[IDX_LAST - $past(issued_ff[IDX_W-1:0])]
		== ($past(first_source_vector) != WORD_ZERO))
		else $error("compressed index mask bit wrong");
	AST_STALL_HOLD: assert property (@(posedge sys_clk) disable iff (!nrst)
		(state_ff == VSC_RUN && !src_valid) |=> $stable(issued_ff))
		else $error("issued without source data");
	AST_SEQ_DST: assert property (@(posedge sys_clk) disable iff (!nrst)
		(ret && op_ff == VSC_OP_VV) |=> dst_we_ff && dst_elem_ff == $past(ret_idx))
		else $error("destination element out of order");
endmodule : vsc_seq

// [verification/vsc_far_model.sv]
`timescale 1ns/1ps
// Source registers, memory and four-stage unit on the far side
module vsc_far_model
	import vsc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic [IDX_W-1:0] src_elem,
	input wire logic [WORD_W-1:0] fu_opa_ff,
	input wire logic [WORD_W-1:0] fu_opb_ff,
	input wire logic mem_req_ff,
	input wire logic mem_we_ff,
	input wire logic [ADDR_W-1:0] mem_addr_ff,
	output logic [WORD_W-1:0] first_source_vector,
	output logic [WORD_W-1:0] second_source_vector,
	output logic [WORD_W-1:0] index_vector_reg,
	output logic [WORD_W-1:0] fu_result
);
	logic [WORD_W-1:0] pipe_ff [4];
	// Zero, positive and negative elements mixed for the index tests
	function automatic logic [WORD_W-1:0] src_a(input logic [IDX_W-1:0] i);
		case (i[1:0])
			2'h0: return WORD_ZERO;
			2'h2: return {1'b1, 57'h0, i};
			default: return {58'h0, i};
		endcase
	endfunction : src_a
	// Memory word tagged with its own address
	function automatic logic [WORD_W-1:0] mem_rd(input logic [ADDR_W-1:0] a);
		return {32'h5a5a0000, a};
	endfunction : mem_rd
	assign first_source_vector = src_a(src_elem);
	assign second_source_vector = {58'h0, src_elem} + 64'h100;
	assign index_vector_reg = {57'h0, src_elem, 1'b0};
	// Read data and sums share one track, so loads see unit timing
	always_ff @(posedge sys_clk)
	begin
		pipe_ff[0] <= (mem_req_ff && !mem_we_ff) ? mem_rd(mem_addr_ff) : fu_opa_ff + fu_opb_ff;
		pipe_ff[1] <= pipe_ff[0];
		pipe_ff[2] <= pipe_ff[1];
		pipe_ff[3] <= pipe_ff[2];
	end
	assign fu_result = pipe_ff[3];
endmodule : vsc_far_model

// [verification/tb_vector_sequencing_chaining.sv]
`timescale 1ns/1ps
module tb_vector_sequencing_chaining;
	import vsc_pkg::*;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic start = 1'b0;
	vsc_op_e op_sel = VSC_OP_VV;
	vsc_test_e test_sel = VSC_T_ZERO;
	logic merge_en = 1'b0;
	logic [CNT_W-1:0] element_count_reg = CNT_ZERO;
	logic [WORD_W-1:0] scalar_operand = WORD_ZERO;
	logic [ADDR_W-1:0] base_address_reg = 32'h100;
	logic [ADDR_W-1:0] addr_increment = 32'h3;
	logic src_valid = 1'b1;
	logic chain_req = 1'b0;
	logic mask_we = 1'b0;
	logic [WORD_W-1:0] mask_wdata = WORD_ZERO;
	logic stall_en = 1'b0;
	logic seen_ok = 1'b0;
	logic [WORD_W-1:0] first_source_vector, second_source_vector, index_vector_reg, fu_result;
	logic [WORD_W-1:0] fu_opa_ff, fu_opb_ff, mem_wdata_ff, dst_data_ff, element_mask_reg, em;
	logic busy, fu_issue, mem_req_ff, mem_we_ff, dst_we_ff, chain_ok, chain_full_ff;
	logic [IDX_W-1:0] src_elem, dst_elem_ff;
	logic [ADDR_W-1:0] mem_addr_ff;
	logic [CNT_W-1:0] written_cnt_ff;
	int err_count = 0, n_checks = 0, cyc = 0, n_dst = 0, n_mem = 0, t_iss = -1, t_dst = -1;
	logic [WORD_W-1:0] dst_got [ELEM_N];
	logic [WORD_W-1:0] wd_got [ELEM_N];
	logic [ADDR_W-1:0] adr_got [ELEM_N];
	always #5 sys_clk = ~sys_clk;
	vsc_seq dut (.sys_clk, .nrst, .start, .op_sel, .test_sel, .merge_en, .element_count_reg,
		.scalar_operand, .base_address_reg, .addr_increment, .src_valid, .first_source_vector,
		.second_source_vector, .index_vector_reg, .fu_result, .chain_req, .mask_we, .mask_wdata,
		.busy, .src_elem, .fu_issue, .fu_opa_ff, .fu_opb_ff, .mem_req_ff, .mem_we_ff,
		.mem_addr_ff, .mem_wdata_ff, .dst_we_ff, .dst_elem_ff, .dst_data_ff, .written_cnt_ff,
		.chain_ok, .chain_full_ff, .element_mask_reg);
	vsc_far_model far (.sys_clk, .src_elem, .fu_opa_ff, .fu_opb_ff, .mem_req_ff, .mem_we_ff,
		.mem_addr_ff, .first_source_vector, .second_source_vector, .index_vector_reg, .fu_result);
	// Log writes and first issue; cut a hang after 3000 cycles
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		src_valid <= !(stall_en && cyc % 3 == 1);
		seen_ok <= seen_ok | (chain_ok === 1'b1);
		if (fu_issue === 1'b1 && t_iss < 0)
			t_iss <= cyc;
		if (dst_we_ff === 1'b1)
		begin
			dst_got[dst_elem_ff] <= dst_data_ff;
			n_dst <= n_dst + 1;
			if (t_dst < 0)
				t_dst <= cyc;
		end
		if (mem_req_ff === 1'b1 && mem_we_ff === 1'b1)
		begin
			adr_got[n_mem] <= mem_addr_ff;
			wd_got[n_mem] <= mem_wdata_ff;
			n_mem <= n_mem + 1;
		end
		if (cyc > 3000)
		begin
			err_count++;
			complete_run();
		end
	end
	task automatic check(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	// One operation from start pulse until busy drops
	task automatic run(input vsc_op_e op, input logic [CNT_W-1:0] cnt);
		int n;
		n = 0;
		@(posedge sys_clk);
		n_dst = 0;
		n_mem = 0;
		t_iss = -1;
		t_dst = -1;
		seen_ok = 1'b0;
		op_sel <= op;
		element_count_reg <= cnt;
		start <= 1'b1;
		@(posedge sys_clk);
		start <= 1'b0;
		@(posedge sys_clk);
		while (busy !== 1'b0 && n < 400)
		begin
			@(posedge sys_clk);
			n++;
		end
		// A run that never drains is a mismatch, not a silent exit
		if (n >= 400)
			err_count++;
		repeat (2) @(posedge sys_clk);
	endtask : run
	// Memory ops of four elements; step is the address spacing
	task automatic mem_case(input vsc_op_e op, input int step, input bit rd);
		logic [ADDR_W-1:0] a;
		run(op, 7'h4);
		check(rd ? n_dst : n_mem, 4);
		for (int i = 0; i < 4; i++)
		begin
			a = 32'h100 + step * i;
			if (rd)
				check(dst_got[i], far.mem_rd(a));
			else
			begin
				check(adr_got[i], a);
				check(wd_got[i], far.src_a(i));
			end
		end
	endtask : mem_case
	task automatic complete_run();
		$display("Checks %0d, errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : complete_run
	initial
	begin
		repeat (6) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		check(element_mask_reg, MASK_RST);
		mask_wdata <= 64'h8000000000000001;
		mask_we <= 1'b1;
		@(posedge sys_clk);
		mask_we <= 1'b0;
		@(posedge sys_clk);
		check(element_mask_reg, 64'h8000000000000001);
		// Full length with a stalling source and a waiting consumer
		stall_en <= 1'b1;
		chain_req <= 1'b1;
		run(VSC_OP_VV, 7'h40);
		check({n_dst, written_cnt_ff}, {32'd64, 7'h40});
		check(chain_full_ff, 1'b1);
		for (int i = 0; i < ELEM_N; i++)
			check(dst_got[i], far.src_a(i) + 64'h100 + i);
		// Scalar broadcast, unstalled, consumer absent at first write
		stall_en <= 1'b0;
		chain_req <= 1'b0;
		scalar_operand <= 64'h7;
		run(VSC_OP_VS, 7'h3);
		check(t_dst - t_iss, 6);
		check({chain_full_ff, seen_ok}, 2'b01);
		for (int i = 0; i < 3; i++)
			check(dst_got[i], far.src_a(i) + 64'h7);
		// Mask holds elements 0 and 63 only
		merge_en <= 1'b1;
		run(VSC_OP_VV, 7'h3);
		merge_en <= 1'b0;
		check(dst_got[1], WORD_ZERO);
		check(dst_got[2], WORD_ZERO);
		check(dst_got[0], 64'h100);
		mem_case(VSC_OP_LOAD, 3, 1'b1);
		mem_case(VSC_OP_STORE, 3, 1'b0);
		mem_case(VSC_OP_GATHER, 2, 1'b1);
		mem_case(VSC_OP_SCATTER, 2, 1'b0);
		// Every index test over zero, positive, negative, positive
		for (int t = 0; t < 4; t++)
		begin
			int k;
			test_sel <= vsc_test_e'(t);
			run(VSC_OP_CIDX, 7'h4);
			k = 0;
			em = WORD_ZERO;
			for (int e = 0; e < 4; e++)
			begin
				logic [WORD_W-1:0] v;
				v = far.src_a(e);
				if (t == 0 ? v == 0 : t == 1 ? v != 0 : t == 2 ? !v[63] && v != 0 : v[63])
				begin
					check(dst_got[k], e);
					k++;
					em[63-e] = 1'b1;
				end
			end
			check(element_mask_reg[63:60], em[63:60]);
			check(n_dst, k);
		end
		// Zero count leaves the sequencer idle
		run(VSC_OP_VV, CNT_ZERO);
		check({n_dst, busy}, 33'h0);
		complete_run();
	end
endmodule : tb_vector_sequencing_chaining
